// *** logic/bridge_queue_ctrl.sv ***
// Bridge transaction queue control: read streaming, read boundary, write claim, delayed and posted writes
// Notes on behaviour
// - Retried read gets queued data once four dwords are held while fetching.
// - After target termination the retried read gets data even below four dwords.
// - Streaming only for 32/32, 64/64 and 32-request/64-target sizes.
// - Streaming only for prefetchable reads.
// - While streaming, keep fetching past the normal prefetch amount.
// - Streaming ends on target disconnect, master termination or 4 KB boundary.
// - No data-to-data wait states to sustain a stream; disconnect instead.
// - Retried prefetchable read may be held up to 16 wait states from frame.
// - Waits only when bridge owns target bus and has framed the matching read.
// - Waiting ends at two quadwords queued; first ready then data.
// - After 16 wait clocks without watermark, stop signals Retry.
// - Never fetch past a 4 KB boundary; disconnect own target-bus read there.
// - Claim memory/I/O writes inside windows on primary, outside on secondary.
// - Memory writes tried as 64-bit, I/O and config writes as 32-bit.
// - I/O and config writes delayed; memory writes delayed when posting disabled.
// - Delayed write: claim, capture address/command/enables/data, answer Retry.
// - A delayed write carries exactly one four-byte data phase.
// - Repeat completes only if address, command, REQ64, enables, data and, with parity checking enabled, parity match.
// - Completed delayed write mirrors normal, master-abort or target-abort end.
// - Posted write: take data, assert ready, forward later on target bus.
// - Posted queues: 128 bytes/4 entries downstream, 256 bytes/8 entries upstream.
// - Accept posted data only with 8 bytes free and, for a first word, an entry free; disconnect at last room.
`timescale 1ns/100ps
module bridge_queue_ctrl (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Retried read on the initiating bus and its fetch on the target bus
	input wire brg_q_pkg::rd_mst_t rd_mst,
	input wire brg_q_pkg::rd_tgt_t rd_tgt,
	output logic rd_trdy,
	output logic rd_stop,
	output logic fetch_more,
	output logic fetch_disc,
	// Write on the initiating bus
	input wire brg_q_pkg::wr_req_t wr_req,
	output brg_q_pkg::wr_rsp_t wr_rsp,
	// Delayed write towards the target bus
	output brg_q_pkg::dw_iss_t dw_iss,
	input wire brg_q_pkg::dw_fin_t dw_fin,
	// Posted write drains
	input wire logic dn_pop_ready,
	output logic dn_pop_valid,
	output brg_q_pkg::pq_word_t dn_pop_word,
	input wire logic up_pop_ready,
	output logic up_pop_valid,
	output brg_q_pkg::pq_word_t up_pop_word
);
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DRAIN} rd_state_t;
	typedef enum logic [1:0] {DW_IDLE, DW_PEND, DW_DONE} dw_state_t;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] mem_base;
		logic [31:0] mem_lim;
		logic [31:0] pf_base;
		logic [31:0] pf_lim;
		logic [31:0] io_base;
		logic [31:0] io_lim;
		logic [7:0] bus_addr;
		logic bus_wr;
		logic [31:0] rdata;
		rd_state_t rd;
		logic [4:0] wcnt;
		logic [6:0] rcq;
		logic tgt_done;
		dw_state_t dw;
		brg_q_pkg::dw_iss_t ent;
		brg_q_pkg::term_t term;
	} st_t;

	st_t st_ff;
	st_t nxt;
	logic bus_take;
	logic [31:0] rmux;
	logic access;
	logic wait_ok;
	logic stream_ok;
	logic rd_end;
	logic [6:0] drained;
	logic is_mem;
	logic is_io;
	logic hit;
	logic claim;
	logic delayed;
	logic match;
	logic post;
	logic room;
	logic last_room_sel;
	logic dn_new_ok, dn_room_ok, dn_last_room;
	logic up_new_ok, up_room_ok, up_last_room;
	logic [8:0] dn_free, up_free;
	brg_q_pkg::pq_word_t push_word;

	function automatic logic in_win(input logic [31:0] a, input logic [31:0] b, input logic [31:0] l);
		in_win = (a >= b) && (a <= l);
	endfunction : in_win

	assign push_word = '{first: wr_req.first, last: wr_req.last, data: wr_req.data};

	posted_write_queue #(.BYTES(brg_q_pkg::DN_BYTES), .ENTRIES(brg_q_pkg::DN_ENTRIES)) u_dn_queue (
		.hclk(hclk),
		.hresetn(hresetn),
		.push_valid(post && wr_req.primary),
		.push_word(push_word),
		.new_ok(dn_new_ok),
		.room_ok(dn_room_ok),
		.last_room(dn_last_room),
		.pop_ready(dn_pop_ready),
		.pop_valid(dn_pop_valid),
		.pop_word(dn_pop_word),
		.free_bytes(dn_free)
	);

	posted_write_queue #(.BYTES(brg_q_pkg::UP_BYTES), .ENTRIES(brg_q_pkg::UP_ENTRIES)) u_up_queue (
		.hclk(hclk),
		.hresetn(hresetn),
		.push_valid(post && !wr_req.primary),
		.push_word(push_word),
		.new_ok(up_new_ok),
		.room_ok(up_room_ok),
		.last_room(up_last_room),
		.pop_ready(up_pop_ready),
		.pop_valid(up_pop_valid),
		.pop_word(up_pop_word),
		.free_bytes(up_free)
	);

	always_comb begin
		nxt = st_ff;
		hreadyout = 1'b1;
		hresp = 1'b0;
		hrdata = st_ff.rdata;
		// Register read mux; unmapped offsets read zero
		rmux = '0;
		unique case (haddr[7:0])
			brg_q_pkg::OFF_CTRL: rmux = st_ff.ctrl;
			brg_q_pkg::OFF_MEM_BASE: rmux = st_ff.mem_base;
			brg_q_pkg::OFF_MEM_LIM: rmux = st_ff.mem_lim;
			brg_q_pkg::OFF_PF_BASE: rmux = st_ff.pf_base;
			brg_q_pkg::OFF_PF_LIM: rmux = st_ff.pf_lim;
			brg_q_pkg::OFF_IO_BASE: rmux = st_ff.io_base;
			brg_q_pkg::OFF_IO_LIM: rmux = st_ff.io_lim;
			brg_q_pkg::OFF_STAT: begin
				rmux[6:0] = st_ff.rcq;
				rmux[brg_q_pkg::STAT_RD_BUSY] = st_ff.rd != RD_IDLE;
				rmux[brg_q_pkg::STAT_DW_PEND] = st_ff.dw == DW_PEND;
				rmux[brg_q_pkg::STAT_DW_DONE] = st_ff.dw == DW_DONE;
				rmux[brg_q_pkg::STAT_TERM +: 2] = st_ff.term;
			end
			brg_q_pkg::OFF_QFREE: begin
				rmux[8:0] = dn_free;
				rmux[brg_q_pkg::QFREE_UP +: 9] = up_free;
			end
			default: rmux = '0;
		endcase
		// Data phase of a write lands in the register latched in the address phase
		if (st_ff.bus_wr) begin
			unique case (st_ff.bus_addr)
				brg_q_pkg::OFF_CTRL: nxt.ctrl = {30'h0, hwdata[1:0]};
				brg_q_pkg::OFF_MEM_BASE: nxt.mem_base = hwdata;
				brg_q_pkg::OFF_MEM_LIM: nxt.mem_lim = hwdata;
				brg_q_pkg::OFF_PF_BASE: nxt.pf_base = hwdata;
				brg_q_pkg::OFF_PF_LIM: nxt.pf_lim = hwdata;
				brg_q_pkg::OFF_IO_BASE: nxt.io_base = hwdata;
				brg_q_pkg::OFF_IO_LIM: nxt.io_lim = hwdata;
				default: nxt.ctrl = st_ff.ctrl;
			endcase
		end
		bus_take = hsel && htrans[1] && hready;
		nxt.bus_wr = bus_take && hwrite;
		if (bus_take) begin
			nxt.bus_addr = haddr[7:0];
			nxt.rdata = hwrite ? st_ff.rdata : rmux;
		end

		// Read completion queue and streaming
		access = (st_ff.rcq >= brg_q_pkg::RD_ACCESS_DW) || st_ff.tgt_done;
		wait_ok = rd_mst.prefetch && rd_tgt.own_gnt && rd_tgt.frame;
		stream_ok = rd_mst.prefetch && !(rd_mst.req64 && !rd_tgt.tgt64);
		fetch_disc = rd_tgt.step && (rd_tgt.fetch_dw == brg_q_pkg::BOUND_4K_LAST);
		rd_trdy = 1'b0;
		rd_stop = 1'b0;
		rd_end = 1'b0;
		unique case (st_ff.rd)
			RD_IDLE: begin
				if (rd_mst.retry) begin
					if (access) begin
						nxt.rd = RD_DRAIN;
					end else if (wait_ok) begin
						nxt.rd = RD_WAIT;
						nxt.wcnt = 5'h01;
					end else begin
						rd_stop = 1'b1;
					end
				end
			end
			RD_WAIT: begin
				if (st_ff.rcq >= brg_q_pkg::RD_LOW_WM_DW) begin
					rd_trdy = 1'b1;
					nxt.rd = RD_DRAIN;
				end else if (rd_mst.mst_term) begin
					rd_end = 1'b1;
				end else if (st_ff.wcnt == brg_q_pkg::RD_WAIT_MAX) begin
					rd_stop = 1'b1;
					nxt.rd = RD_IDLE;
				end else begin
					nxt.wcnt = st_ff.wcnt + 5'h01;
				end
			end
			RD_DRAIN: begin
				if (rd_mst.mst_term) begin
					rd_end = 1'b1;
				end else if (st_ff.rcq == '0) begin
					// An empty queue disconnects rather than inserting a wait
					rd_stop = 1'b1;
					rd_end = 1'b1;
				end else begin
					rd_trdy = 1'b1;
				end
			end
			default: nxt.rd = RD_IDLE;
		endcase
		fetch_more = (st_ff.rd != RD_IDLE) && stream_ok && !st_ff.tgt_done && !fetch_disc
			&& (st_ff.rcq < brg_q_pkg::RD_CAP_DW - 7'h02);
		drained = (rd_trdy && rd_mst.take) ? ((rd_mst.req64 && rd_tgt.tgt64) ? 7'h02 : 7'h01) : 7'h00;
		if (rd_end) begin
			// Data fetched but not taken is dropped with the completion
			nxt.rd = RD_IDLE;
			nxt.rcq = '0;
			nxt.tgt_done = rd_tgt.tgt_term || fetch_disc;
		end else begin
			nxt.rcq = st_ff.rcq + 7'(rd_tgt.fill_dw) - drained;
			nxt.tgt_done = st_ff.tgt_done || rd_tgt.tgt_term || fetch_disc;
		end

		// Write claim and split into delayed or posted
		is_mem = (wr_req.cmd == brg_q_pkg::CMD_MEM_WR) || (wr_req.cmd == brg_q_pkg::CMD_MWI);
		is_io = wr_req.cmd == brg_q_pkg::CMD_IO_WR;
		hit = is_mem ? (in_win(wr_req.addr, st_ff.mem_base, st_ff.mem_lim)
			|| in_win(wr_req.addr, st_ff.pf_base, st_ff.pf_lim))
			: in_win(wr_req.addr, st_ff.io_base, st_ff.io_lim);
		claim = wr_req.valid && (((is_mem || is_io) && (wr_req.primary == hit))
			|| ((wr_req.cmd == brg_q_pkg::CMD_CFG_WR) && wr_req.primary));
		delayed = !is_mem || st_ff.ctrl[brg_q_pkg::CTRL_POST_DIS];
		match = (wr_req.addr == st_ff.ent.addr) && (wr_req.cmd == st_ff.ent.cmd)
			&& (wr_req.req64 == st_ff.ent.req64) && (wr_req.be[3:0] == st_ff.ent.be)
			&& (wr_req.data[31:0] == st_ff.ent.data)
			&& (!st_ff.ctrl[brg_q_pkg::CTRL_PAR_EN] || (wr_req.par == st_ff.ent.par));
		post = claim && !delayed;
		room = wr_req.primary ? (wr_req.first ? dn_new_ok : dn_room_ok) : (wr_req.first ? up_new_ok : up_room_ok);
		last_room_sel = wr_req.primary ? dn_last_room : up_last_room;
		wr_rsp = '0;
		wr_rsp.devsel = claim;
		wr_rsp.wide = claim && is_mem;
		if (post) begin
			wr_rsp.trdy = room;
			wr_rsp.stop = !room || last_room_sel;
		end
		if (claim && delayed) begin
			unique case (st_ff.dw)
				DW_IDLE: begin
					nxt.ent = '{valid: 1'b1, cmd: wr_req.cmd, addr: wr_req.addr, be: wr_req.be[3:0],
						req64: wr_req.req64, par: wr_req.par, data: wr_req.data[31:0]};
					nxt.dw = DW_PEND;
					wr_rsp.stop = 1'b1;
				end
				DW_PEND: wr_rsp.stop = 1'b1;
				DW_DONE: begin
					wr_rsp.stop = 1'b1;
					if (match) begin
						nxt.dw = DW_IDLE;
						wr_rsp.trdy = st_ff.term == brg_q_pkg::TM_NORMAL;
						wr_rsp.mabort = st_ff.term == brg_q_pkg::TM_MABORT;
						wr_rsp.tabort = st_ff.term == brg_q_pkg::TM_TABORT;
					end
				end
				default: nxt.dw = DW_IDLE;
			endcase
		end
		if ((st_ff.dw == DW_PEND) && dw_fin.valid) begin
			nxt.dw = DW_DONE;
			nxt.term = dw_fin.term;
		end
		dw_iss = st_ff.ent;
		dw_iss.valid = st_ff.dw == DW_PEND;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '{ctrl: brg_q_pkg::CTRL_RST, mem_base: brg_q_pkg::BASE_RST, mem_lim: brg_q_pkg::LIM_RST,
				pf_base: brg_q_pkg::BASE_RST, pf_lim: brg_q_pkg::LIM_RST, io_base: brg_q_pkg::BASE_RST,
				io_lim: brg_q_pkg::LIM_RST, rd: RD_IDLE, dw: DW_IDLE, term: brg_q_pkg::TM_NORMAL, default: '0};
		end else begin
			st_ff <= nxt;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_retry_idle;
		st_ff.rd == RD_IDLE && rd_mst.retry;
	endsequence
	sequence s_wait_start;
		s_retry_idle and (!access && wait_ok);
	endsequence
	sequence s_dw_repeat;
		st_ff.dw == DW_DONE && claim && delayed;
	endsequence

	property p_rd_access;
		(s_retry_idle and access) |=> st_ff.rd == RD_DRAIN;
	endproperty
	a_rd_access: assert property (p_rd_access) else $error("granted read did not drain");

	property p_wait_bound;
		s_wait_start |-> ##[1:16] (rd_trdy || rd_stop || rd_end);
	endproperty
	a_wait_bound: assert property (p_wait_bound) else $error("read wait ran past sixteen clocks");

	property p_no_wait;
		(s_retry_idle and (!access && !wait_ok)) |-> rd_stop && !rd_trdy ##1 st_ff.rd == RD_IDLE;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("read waited without owning target bus");

	property p_low_wm;
		(st_ff.rd == RD_WAIT && st_ff.rcq >= 7'h04) |-> rd_trdy && !rd_stop ##1 st_ff.rd == RD_DRAIN;
	endproperty
	a_low_wm: assert property (p_low_wm) else $error("watermark did not end waiting");

	property p_wait_stop;
		(st_ff.rd == RD_WAIT && rd_stop) |-> st_ff.wcnt == 5'h10 && $past(st_ff.rd) == RD_WAIT;
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("retry stop at wrong wait count");

	property p_stream_kind;
		fetch_more |-> rd_mst.prefetch && !(rd_mst.req64 && !rd_tgt.tgt64) && !fetch_disc;
	endproperty
	a_stream_kind: assert property (p_stream_kind) else $error("stream on illegal size or space");

	property p_dw_capture;
		(st_ff.dw == DW_IDLE && claim && delayed) |-> wr_rsp.stop && !wr_rsp.trdy ##1 dw_iss.valid;
	endproperty
	a_dw_capture: assert property (p_dw_capture) else $error("delayed write not retried and queued");

	property p_dw_mismatch;
		(s_dw_repeat and !match) |-> wr_rsp.stop && !wr_rsp.trdy ##1 st_ff.dw == DW_DONE;
	endproperty
	a_dw_mismatch: assert property (p_dw_mismatch) else $error("mismatched repeat completed");

	property p_dw_term;
		(s_dw_repeat and match) |-> (wr_rsp.tabort == (st_ff.term == brg_q_pkg::TM_TABORT))
			&& (wr_rsp.trdy == (st_ff.term == brg_q_pkg::TM_NORMAL)) ##1 st_ff.dw == DW_IDLE;
	endproperty
	a_dw_term: assert property (p_dw_term) else $error("delayed write end does not mirror target");

	property p_post_full;
		(post && wr_rsp.trdy && last_room_sel) |-> wr_rsp.stop;
	endproperty
	a_post_full: assert property (p_post_full) else $error("no disconnect on last posted room");
endmodule : bridge_queue_ctrl

// *** logic/brg_q_pkg.sv ***
// Shared constants and carrier types of the bridge transaction queue controller
package brg_q_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MEM_BASE = 8'h04;
	localparam logic [7:0] OFF_MEM_LIM = 8'h08;
	localparam logic [7:0] OFF_PF_BASE = 8'h0c;
	localparam logic [7:0] OFF_PF_LIM = 8'h10;
	localparam logic [7:0] OFF_IO_BASE = 8'h14;
	localparam logic [7:0] OFF_IO_LIM = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;
	localparam logic [7:0] OFF_QFREE = 8'h20;
	localparam int CTRL_POST_DIS = 0;
	localparam int CTRL_PAR_EN = 1;
	localparam int STAT_RD_BUSY = 8;
	localparam int STAT_DW_PEND = 9;
	localparam int STAT_DW_DONE = 10;
	localparam int STAT_TERM = 11;
	localparam int QFREE_UP = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] BASE_RST = 32'hffff_ffff;
	localparam logic [31:0] LIM_RST = 32'h0000_0000;
	localparam logic [6:0] RD_ACCESS_DW = 7'h04;
	localparam logic [6:0] RD_LOW_WM_DW = 7'h04;
	localparam logic [6:0] RD_CAP_DW = 7'h40;
	localparam logic [4:0] RD_WAIT_MAX = 5'h10;
	localparam logic [9:0] BOUND_4K_LAST = 10'h3ff;
	localparam int DN_BYTES = 128;
	localparam int DN_ENTRIES = 4;
	localparam int UP_BYTES = 256;
	localparam int UP_ENTRIES = 8;
	localparam int ROOM_BYTES = 8;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] CMD_MWI = 4'hf;

	typedef enum logic [1:0] {TM_NORMAL, TM_MABORT, TM_TABORT} term_t;

	typedef struct packed {
		logic valid;
		logic primary;
		logic first;
		logic last;
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [7:0] be;
		logic req64;
		logic par;
		logic [63:0] data;
	} wr_req_t;

	typedef struct packed {
		logic devsel;
		logic trdy;
		logic stop;
		logic mabort;
		logic tabort;
		logic wide;
	} wr_rsp_t;

	typedef struct packed {
		logic retry;
		logic prefetch;
		logic req64;
		logic take;
		logic mst_term;
	} rd_mst_t;

	typedef struct packed {
		logic own_gnt;
		logic frame;
		logic tgt64;
		logic [1:0] fill_dw;
		logic tgt_term;
		logic step;
		logic [9:0] fetch_dw;
	} rd_tgt_t;

	typedef struct packed {
		logic valid;
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [3:0] be;
		logic req64;
		logic par;
		logic [31:0] data;
	} dw_iss_t;

	typedef struct packed {
		logic valid;
		term_t term;
	} dw_fin_t;

	typedef struct packed {
		logic first;
		logic last;
		logic [63:0] data;
	} pq_word_t;
endpackage : brg_q_pkg

// *** logic/posted_write_queue.sv ***
// Posted write data queue of quadwords with transaction entry accounting
`timescale 1ns/100ps
module posted_write_queue #(
	parameter int BYTES = 128,
	parameter int ENTRIES = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Fill side
	input wire logic push_valid,
	input wire brg_q_pkg::pq_word_t push_word,
	output logic new_ok,
	output logic room_ok,
	output logic last_room,
	// Drain side
	input wire logic pop_ready,
	output logic pop_valid,
	output brg_q_pkg::pq_word_t pop_word,
	output logic [8:0] free_bytes
);
	localparam int DEPTH = BYTES / 8;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	typedef struct packed {
		brg_q_pkg::pq_word_t [DEPTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic [3:0] ent;
	} pq_st_t;

	pq_st_t st_ff;
	pq_st_t nxt_st;
	logic push;
	logic pop;

	always_comb begin
		free_bytes = 9'(BYTES - 8 * int'(st_ff.cnt));
		// A word needs one quadword slot; a new transaction also needs an entry
		room_ok = free_bytes >= 9'(brg_q_pkg::ROOM_BYTES);
		new_ok = room_ok && (int'(st_ff.ent) < ENTRIES);
		last_room = free_bytes == 9'(brg_q_pkg::ROOM_BYTES);
		pop_valid = st_ff.cnt != '0;
		pop_word = st_ff.mem[st_ff.rp];
		push = push_valid && (push_word.first ? new_ok : room_ok);
		pop = pop_valid && pop_ready;
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wp] = push_word;
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = st_ff.rp + 1'b1;
		end
		nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
		nxt_st.ent = st_ff.ent + 4'(push && push_word.first) - 4'(pop && pop_word.last);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule : posted_write_queue

// *** tb/target_bus_model.sv ***
// Far-side target bus model: ends delayed writes and drains the posted queues
`timescale 1ns/100ps
module target_bus_model #(
	parameter int LAT = 5
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bench control
	input wire logic stall,
	input wire brg_q_pkg::term_t term,
	// Delayed write
	input wire brg_q_pkg::dw_iss_t dw_iss,
	output brg_q_pkg::dw_fin_t dw_fin,
	// Posted drains
	output logic dn_pop_ready,
	output logic up_pop_ready
);
	int cnt_ff;
	assign dn_pop_ready = !stall;
	assign up_pop_ready = !stall;
	// One ending per pending entry, LAT+1 cycles after the entry is issued on the target bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 0;
			dw_fin <= '0;
		end else begin
			dw_fin.valid <= dw_iss.valid && cnt_ff == LAT;
			dw_fin.term <= term;
			cnt_ff <= !dw_iss.valid ? 0 : (cnt_ff > LAT ? cnt_ff : cnt_ff + 1);
		end
	end
endmodule : target_bus_model

// *** tb/tb_top.sv ***
// Register, read stream, delayed and posted write tests of the bridge queue controller
`timescale 1ns/100ps
module tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, stall;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rd_trdy, rd_stop, fetch_more, fetch_disc, dn_pop_ready, dn_pop_valid, up_pop_ready, up_pop_valid;
	brg_q_pkg::rd_mst_t rd_mst;
	brg_q_pkg::rd_tgt_t rd_tgt;
	brg_q_pkg::wr_req_t wr_req, r;
	brg_q_pkg::wr_rsp_t wr_rsp;
	brg_q_pkg::dw_iss_t dw_iss;
	brg_q_pkg::dw_fin_t dw_fin;
	brg_q_pkg::pq_word_t dn_pop_word, up_pop_word;
	brg_q_pkg::term_t term;
	int n_errors, comparisons, n;
	assign hready = hreadyout;

	bridge_queue_ctrl bridge_queue_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rd_mst(rd_mst), .rd_tgt(rd_tgt),
		.rd_trdy(rd_trdy), .rd_stop(rd_stop), .fetch_more(fetch_more), .fetch_disc(fetch_disc),
		.wr_req(wr_req), .wr_rsp(wr_rsp), .dw_iss(dw_iss), .dw_fin(dw_fin), .dn_pop_ready(dn_pop_ready),
		.dn_pop_valid(dn_pop_valid), .dn_pop_word(dn_pop_word), .up_pop_ready(up_pop_ready),
		.up_pop_valid(up_pop_valid), .up_pop_word(up_pop_word));
	target_bus_model target_bus_model_i (.hclk(hclk), .hresetn(hresetn), .stall(stall), .term(term),
		.dw_iss(dw_iss), .dw_fin(dw_fin), .dn_pop_ready(dn_pop_ready), .up_pop_ready(up_pop_ready));

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wait_rdy();
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) chk("hready", 0, 1);
	endtask : wait_rdy

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk("hresp", hresp, 0);
	endtask : ahb

	function automatic brg_q_pkg::wr_req_t mk(input logic p, input logic [3:0] c, input logic [31:0] a,
		input logic [63:0] d, input logic [1:0] fl);
		mk = '{valid: 1'b1, primary: p, first: fl[1], last: fl[0], cmd: c, addr: a, be: 8'hff,
			req64: 1'b0, par: 1'b0, data: d};
	endfunction : mk

	function automatic brg_q_pkg::rd_mst_t rm(input logic rt, input logic pf, input logic tk, input logic mt);
		rm = '{retry: rt, prefetch: pf, req64: 1'b0, take: tk, mst_term: mt};
	endfunction : rm

	function automatic brg_q_pkg::rd_tgt_t rt(input logic gf, input logic [1:0] f, input logic tt,
		input logic st, input logic [9:0] fa);
		rt = '{own_gnt: gf, frame: gf, tgt64: 1'b0, fill_dw: f, tgt_term: tt, step: st, fetch_dw: fa};
	endfunction : rt

	task wr(input brg_q_pkg::wr_req_t q);
		@(posedge hclk);
		wr_req <= q;
		#1;
	endtask : wr

	task rdc(input brg_q_pkg::rd_mst_t m, input brg_q_pkg::rd_tgt_t t);
		@(posedge hclk);
		rd_mst <= m;
		rd_tgt <= t;
		#1;
	endtask : rdc

	task report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial begin
		#80000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		{hresetn, hsel, hwrite, stall, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		rd_mst = '0;
		rd_tgt = '0;
		wr_req = '0;
		term = brg_q_pkg::TM_NORMAL;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, brg_q_pkg::OFF_CTRL, 0, rd);
		chk("ctrl_rst", rd, brg_q_pkg::CTRL_RST);
		ahb(0, brg_q_pkg::OFF_MEM_BASE, 0, rd);
		chk("base_rst", rd, brg_q_pkg::BASE_RST);
		ahb(0, brg_q_pkg::OFF_IO_LIM, 0, rd);
		chk("lim_rst", rd, brg_q_pkg::LIM_RST);
		ahb(0, 8'h24, 0, rd);
		chk("unmapped", rd, 0);
		ahb(1, brg_q_pkg::OFF_MEM_BASE, 32'h1000_0000, rd);
		ahb(1, brg_q_pkg::OFF_MEM_LIM, 32'h1000_ffff, rd);
		ahb(1, brg_q_pkg::OFF_IO_BASE, 32'h0000_1000, rd);
		ahb(1, brg_q_pkg::OFF_IO_LIM, 32'h0000_1fff, rd);
		ahb(0, brg_q_pkg::OFF_MEM_LIM, 0, rd);
		chk("mem_lim", rd, 32'h1000_ffff);
		$display("registers done");
		wr(mk(1, brg_q_pkg::CMD_MEM_WR, 32'h1000_0100, 64'h1, 2'b11));
		chk("pri_in_sel", wr_rsp.devsel, 1);
		chk("pri_in_trdy", wr_rsp.trdy, 1);
		chk("pri_in_wide", wr_rsp.wide, 1);
		wr(mk(1, brg_q_pkg::CMD_MEM_WR, 32'h2000_0000, 64'h2, 2'b11));
		chk("pri_out_sel", wr_rsp.devsel, 0);
		wr(mk(0, brg_q_pkg::CMD_MEM_WR, 32'h2000_0000, 64'h3, 2'b11));
		chk("sec_out_sel", wr_rsp.devsel, 1);
		wr(mk(0, brg_q_pkg::CMD_MEM_WR, 32'h1000_0100, 64'h4, 2'b11));
		chk("sec_in_sel", wr_rsp.devsel, 0);
		wr('0);
		$display("claim done");
		for (int t = 0; t < 3; t++) begin
			term <= brg_q_pkg::term_t'(t);
			if (t == 2) ahb(1, brg_q_pkg::OFF_CTRL, 32'h1, rd);
			r = mk(1, t == 0 ? brg_q_pkg::CMD_CFG_WR : (t == 1 ? brg_q_pkg::CMD_IO_WR : brg_q_pkg::CMD_MEM_WR),
				t == 0 ? 32'h0 : (t == 1 ? 32'h1004 : 32'h1000_0200), {32'h5555_0000, 32'hc0de_0000 + t}, 2'b11);
			wr(r);
			chk("dly_stop", wr_rsp.stop, 1);
			chk("dly_trdy", wr_rsp.trdy, 0);
			if (t == 1) chk("io_wide", wr_rsp.wide, 0);
			wr('0);
			chk("iss_data", dw_iss.data, 32'hc0de_0000 + t);
			chk("iss_be", dw_iss.be, 4'hf);
			chk("iss_cmd", dw_iss.cmd, r.cmd);
			for (n = 0; n < 100 && dw_fin.valid !== 1'b1; n++) @(posedge hclk);
			chk("fin_seen", dw_fin.valid, 1);
			r.data = r.data ^ 64'h1;
			wr(r);
			chk("mism_trdy", wr_rsp.trdy, 0);
			chk("mism_stop", wr_rsp.stop, 1);
			r.data = r.data ^ 64'h1;
			wr(r);
			chk("cpl_trdy", wr_rsp.trdy, t == 0);
			chk("cpl_mab", wr_rsp.mabort, t == 1);
			chk("cpl_tab", wr_rsp.tabort, t == 2);
			wr('0);
		end
		ahb(1, brg_q_pkg::OFF_CTRL, 32'h0, rd);
		$display("delayed done");
		for (int i = 0; i < 2; i++) begin
			rdc(rm(1, i == 0, 0, 0), rt(i == 1, 0, 0, 0, 0));
			chk("rd_nowait_stop", rd_stop, 1);
			rdc('0, '0);
		end
		rdc(rm(1, 1, 0, 0), rt(1, 0, 0, 0, 0));
		for (int i = 1; i <= 16; i++) begin
			rdc('0, rt(1, 0, 0, 0, 0));
			chk("rd_wait_stop", rd_stop, i == 16);
			if (i < 16) chk("rd_wait_trdy", rd_trdy, 0);
		end
		rdc('0, '0);
		rdc(rm(1, 1, 0, 0), rt(1, 0, 0, 0, 0));
		rdc(rm(0, 1, 0, 0), rt(1, 2, 0, 1, 10'h3fe));
		chk("wm_trdy0", rd_trdy, 0);
		chk("more", fetch_more, 1);
		chk("disc0", fetch_disc, 0);
		rdc('{retry: 1'b0, prefetch: 1'b1, req64: 1'b1, take: 1'b0, mst_term: 1'b0}, rt(1, 2, 0, 0, 0));
		chk("wm_trdy1", rd_trdy, 0);
		chk("more64", fetch_more, 0);
		rdc('0, rt(1, 0, 0, 1, 10'h3ff));
		chk("wm_trdy2", rd_trdy, 1);
		chk("disc1", fetch_disc, 1);
		rdc(rm(0, 1, 1, 1), rt(1, 0, 0, 0, 0));
		rdc('0, '0);
		ahb(0, brg_q_pkg::OFF_STAT, 0, rd);
		chk("stat_idle", rd[8:0], 0);
		rdc('0, rt(0, 1, 1, 0, 0));
		rdc(rm(1, 0, 0, 0), '0);
		rdc(rm(0, 0, 1, 0), '0);
		chk("short_trdy", rd_trdy, 1);
		rdc('0, '0);
		chk("empty_stop", rd_stop, 1);
		rdc('0, '0);
		$display("read done");
		stall <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			wr(mk(1, brg_q_pkg::CMD_MEM_WR, 32'h1000_0400 + 8 * i, 64'(i), {i == 0, i == 15}));
			chk("fill_trdy", wr_rsp.trdy, 1);
			chk("fill_stop", wr_rsp.stop, i == 15);
		end
		wr(mk(1, brg_q_pkg::CMD_MEM_WR, 32'h1000_0500, 64'h0, 2'b11));
		chk("full_trdy", wr_rsp.trdy, 0);
		wr('0);
		ahb(0, brg_q_pkg::OFF_QFREE, 0, rd);
		chk("qfree_full", rd, 32'h0100_0000);
		chk("held_word", {dn_pop_valid, dn_pop_word.first, dn_pop_word.data[29:0]}, 32'hc000_0000);
		// Upstream holds eight transactions; the ninth is refused although data space remains
		for (int i = 0; i < 9; i++) begin
			wr(mk(0, brg_q_pkg::CMD_MEM_WR, 32'h2000_0000 + 8 * i, 64'(i), 2'b11));
			chk("up_ent_trdy", wr_rsp.trdy, i < 8);
		end
		wr('0);
		chk("up_held", {up_pop_valid, up_pop_word.last, up_pop_word.data[29:0]}, 32'hc000_0000);
		stall <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge hclk);
			chk("drain", {dn_pop_valid, dn_pop_word.last, dn_pop_word.data[29:0]}, {1'b1, i == 15, 30'(i)});
		end
		ahb(0, brg_q_pkg::OFF_QFREE, 0, rd);
		chk("qfree_empty", rd, 32'h0100_0080);
		$display("posted done");
		report_and_stop();
	end
endmodule : tb_top
